// ### common/lsq_pkg.sv
// constants, enums and carriers of the level sensor query responder
package lsq_pkg;
  // clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int ONE_SEC_S = 1;
  localparam int CYC_PER_SEC = ONE_SEC_S * CLK_HZ;
  localparam int BAUD_DEF = 19200;
  localparam logic [15:0] BAUD_DIV = 16'(CLK_HZ / BAUD_DEF);
  localparam logic [6:0] EXP_AVG_S = 7'h05;
  localparam logic [6:0] AVG_MAX_S = 7'h5a;
  // protocol bytes
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] BCAST_ID = 8'hff;
  localparam logic [7:0] PFX_QUERY = 8'h31;
  localparam logic [7:0] PFX_RESP = 8'h3e;
  localparam logic [7:0] OP_READ = 8'h06;
  localparam logic [7:0] OP_CONT = 8'h07;
  localparam logic [7:0] ACK_OK = 8'h00;
  // frame lengths in bytes
  localparam logic [4:0] TXT_LEN = 5'h16;
  localparam logic [4:0] BIN_DATA_LEN = 5'h09;
  localparam logic [4:0] BIN_ACK_LEN = 5'h05;
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PERIOD = 4'h1;
  localparam logic [3:0] REG_NET_ID = 4'h2;
  localparam logic [3:0] REG_MAX_N = 4'h3;
  localparam logic [3:0] REG_AVG_INT = 4'h4;
  localparam logic [3:0] REG_COEF = 4'h5;
  localparam logic [3:0] REG_STATUS = 4'h6;
  localparam logic [3:0] REG_AVG_FREQ = 4'h7;
  // control field positions
  localparam int CTRL_AUTO_LSB = 0;
  localparam int CTRL_NET_BIT = 2;
  localparam int CTRL_TCOMP_BIT = 3;
  localparam int CTRL_AVGEXP_BIT = 4;
  // reset values
  localparam logic [7:0] NET_ID_RST = 8'h01;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [15:0] MAX_N_RST = 16'hffff;
  localparam logic [6:0] AVG_INT_RST = 7'h00;
  localparam logic [15:0] COEF_ONE = 16'h0100;

  typedef enum logic [1:0] {AUTO_OFF = 2'b00, AUTO_BIN = 2'b01, AUTO_TEXT = 2'b10} lsq_auto_e;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_TEXT = 2'b01, TX_BIN = 2'b10, TX_ACK = 2'b11} lsq_tx_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } lsq_bus_s;

  typedef struct packed {
    logic [15:0] freq;
    logic [7:0] temp;
    logic [15:0] level;
  } lsq_meas_s;
endpackage

// ### rtl/lsq_responder.sv
// serial command interpreter of the capacitive level sensor
// Notes on behaviour
// - auto output off: only replies to terminal requests, nothing spontaneous
// - auto output binary: binary data frames repeat at the output period
// - auto output text: text data lines repeat at the output period
// - period held in whole seconds, used only while auto output or a periodic or continuous command is live
// - stand-alone mode answers commands whatever identifier they carry
// - network mode answers only own identifier or 255, ignores the rest
// - level ceiling 0..65535 kept; level output scaled to it
// - exponential averaging uses a fixed 5 s interval on frequency
// - moving average uses a programmable interval of 0 to 90 s
// - temperature compensation switch, coefficient defaults to one (no effect)
// - bytes 0x44 0x4f are the single read command
// - reply carries instantaneous frequency, temperature or error code, level
// - text line F=xxxx t=xx N=xxxx.0 then CR LF
// - every numeric text value is hexadecimal ASCII
// - bytes 0x44 0x50 are the periodic output command
// - after it, the same text line repeats at the output period
// - zero output period means no periodic data at all
// - any valid command suspends automatic text output until reset or a control write choosing auto text
// - read command or settings change shuts periodic text output off
// - both binary frames and ASCII sequences are taken and answered
// - default line speed 19200 baud
// - network identifier defaults to 1
//
// Local design decisions: the register addresses and strobed register access.
module lsq_responder #(
  parameter int CYC_PER_SEC = lsq_pkg::CYC_PER_SEC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // register port
  input wire lsq_pkg::lsq_bus_s bus,
  output logic [15:0] rd_data,
  // received byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // live measurements
  input wire lsq_pkg::lsq_meas_s meas,
  // transmitted byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // divisor for the serial line
  output logic [15:0] baud_div
);
  typedef struct packed {
    lsq_pkg::lsq_auto_e auto_mode;
    logic net_mode;
    logic tcomp_en;
    logic avg_exp;
    logic [15:0] period;
    logic [7:0] net_id;
    logic [15:0] max_n;
    logic [6:0] avg_int;
    logic [15:0] coef;
    logic [15:0] rdata;
    logic got_d;
    logic [1:0] bin_idx;
    logic [7:0] bin_addr;
    logic [7:0] bin_op;
    logic [7:0] bin_crc;
    logic suspend;
    logic dp_on;
    logic bin_on;
    lsq_pkg::lsq_tx_e req_st;
    logic [31:0] pre;
    logic [15:0] per_cnt;
    logic per_due;
    logic [15:0] avg_f;
    lsq_pkg::lsq_tx_e tx_st;
    logic [7:0] tx_op;
    logic [4:0] tx_idx;
    logic [7:0] tx_byte;
    logic [7:0] tx_crc;
    logic [15:0] snap_f;
    logic [7:0] snap_t;
    logic [15:0] snap_n;
  } lsq_state_s;

  lsq_state_s q, d;

  function automatic logic [7:0] crc8(input logic [7:0] b, input logic [7:0] c);
    logic [7:0] x;
    logic [7:0] r;
    x = b;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (x[0] ^ r[0]) begin
        r = ((r ^ 8'h18) >> 1) | 8'h80;
      end else begin
        r = r >> 1;
      end
      x = x >> 1;
    end
    return r;
  endfunction

  function automatic logic [7:0] hexc(input logic [3:0] v);
    return (v < 4'ha) ? 8'(8'h30 + {4'h0, v}) : 8'(8'h37 + {4'h0, v});
  endfunction

  // byte idx of the frame st; crc is the running CRC-8 of bytes before it
  function automatic logic [7:0] frame_byte(input lsq_pkg::lsq_tx_e st, input logic [7:0] op,
                                            input logic [4:0] idx, input logic [15:0] f,
                                            input logic [7:0] t, input logic [15:0] n,
                                            input logic [7:0] id, input logic [7:0] crc);
    logic [7:0] b;
    b = 8'h00;
    if (st == lsq_pkg::TX_TEXT) begin
      unique case (idx)
        5'h00: b = 8'h46;
        5'h01, 5'h08, 5'h0d: b = 8'h3d;
        5'h02: b = hexc(f[15:12]);
        5'h03: b = hexc(f[11:8]);
        5'h04: b = hexc(f[7:4]);
        5'h05: b = hexc(f[3:0]);
        5'h06, 5'h0b: b = 8'h20;
        5'h07: b = 8'h74;
        5'h09: b = hexc(t[7:4]);
        5'h0a: b = hexc(t[3:0]);
        5'h0c: b = 8'h4e;
        5'h0e: b = hexc(n[15:12]);
        5'h0f: b = hexc(n[11:8]);
        5'h10: b = hexc(n[7:4]);
        5'h11: b = hexc(n[3:0]);
        5'h12: b = 8'h2e;
        5'h13: b = 8'h30;
        5'h14: b = lsq_pkg::CH_CR;
        5'h15: b = lsq_pkg::CH_LF;
        default: b = 8'h00;
      endcase
    end else begin
      unique case (idx)
        5'h00: b = lsq_pkg::PFX_RESP;
        5'h01: b = id;
        5'h02: b = op;
        5'h03: b = (st == lsq_pkg::TX_ACK) ? lsq_pkg::ACK_OK : t;
        5'h04: b = (st == lsq_pkg::TX_ACK) ? crc : n[7:0];
        5'h05: b = n[15:8];
        5'h06: b = f[7:0];
        5'h07: b = f[15:8];
        5'h08: b = crc;
        default: b = 8'h00;
      endcase
    end
    return b;
  endfunction

  function automatic logic [4:0] frame_len(input lsq_pkg::lsq_tx_e st);
    return (st == lsq_pkg::TX_TEXT) ? lsq_pkg::TXT_LEN :
           (st == lsq_pkg::TX_ACK) ? lsq_pkg::BIN_ACK_LEN : lsq_pkg::BIN_DATA_LEN;
  endfunction

  logic sec_tick;
  logic text_en;
  logic bin_en;
  logic addr_ok;
  logic cfg_wr;
  logic [31:0] lvl_prod;
  logic [31:0] comp_prod;
  logic [15:0] level_out;
  logic [6:0] avg_div;
  logic signed [17:0] avg_diff;
  logic signed [17:0] avg_step;
  logic [7:0] crc_nx;
  lsq_pkg::lsq_tx_e start_st;
  logic [7:0] start_op;

  assign sec_tick = (q.pre == 32'(CYC_PER_SEC - 1));
  // automatic text survives only until the first valid command or a settings write that does not choose auto text
  assign text_en = q.dp_on || (q.auto_mode == lsq_pkg::AUTO_TEXT && !q.suspend);
  assign bin_en = q.bin_on || (q.auto_mode == lsq_pkg::AUTO_BIN);
  assign addr_ok = !q.net_mode || (q.bin_addr == q.net_id) || (q.bin_addr == lsq_pkg::BCAST_ID);
  assign cfg_wr = bus.wr && (bus.addr <= lsq_pkg::REG_COEF);
  assign lvl_prod = meas.level * q.max_n;
  assign comp_prod = lvl_prod[31:16] * q.coef;
  // unity coefficient leaves the level untouched; larger ones scale it up, saturating at 16'hffff
  assign level_out = !q.tcomp_en ? lvl_prod[31:16] :
                     (|comp_prod[31:24]) ? 16'hffff : comp_prod[23:8];
  assign avg_div = q.avg_exp ? lsq_pkg::EXP_AVG_S : q.avg_int;
  assign avg_diff = $signed({2'b00, meas.freq}) - $signed({2'b00, q.avg_f});
  // one divider shared by both averaging types, stepped once a second
  assign avg_step = (avg_div == 7'h00) ? avg_diff : avg_diff / $signed({11'h000, avg_div});
  assign crc_nx = crc8(q.tx_byte, q.tx_crc);
  assign start_st = (q.req_st != lsq_pkg::TX_IDLE) ? q.req_st :
                    text_en ? lsq_pkg::TX_TEXT : lsq_pkg::TX_BIN;
  assign start_op = (q.req_st == lsq_pkg::TX_BIN) ? lsq_pkg::OP_READ : lsq_pkg::OP_CONT;

  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    d.pre = sec_tick ? 32'h0000_0000 : q.pre + 32'h0000_0001;
    // register port
    if (bus.rd) begin
      unique case (bus.addr)
        lsq_pkg::REG_CTRL: d.rdata = {11'h000, q.avg_exp, q.tcomp_en, q.net_mode, q.auto_mode};
        lsq_pkg::REG_PERIOD: d.rdata = q.period;
        lsq_pkg::REG_NET_ID: d.rdata = {8'h00, q.net_id};
        lsq_pkg::REG_MAX_N: d.rdata = q.max_n;
        lsq_pkg::REG_AVG_INT: d.rdata = {9'h000, q.avg_int};
        lsq_pkg::REG_COEF: d.rdata = q.coef;
        lsq_pkg::REG_STATUS: d.rdata = {11'h000, q.tx_st != lsq_pkg::TX_IDLE, q.per_due,
                                        q.bin_on, q.dp_on, q.suspend};
        lsq_pkg::REG_AVG_FREQ: d.rdata = q.avg_f;
        default: d.rdata = 16'h0000;
      endcase
    end
    if (bus.wr) begin
      unique case (bus.addr)
        lsq_pkg::REG_CTRL: begin
          d.auto_mode = lsq_pkg::lsq_auto_e'(bus.wdata[lsq_pkg::CTRL_AUTO_LSB +: 2]);
          d.net_mode = bus.wdata[lsq_pkg::CTRL_NET_BIT];
          d.tcomp_en = bus.wdata[lsq_pkg::CTRL_TCOMP_BIT];
          d.avg_exp = bus.wdata[lsq_pkg::CTRL_AVGEXP_BIT];
        end
        lsq_pkg::REG_PERIOD: d.period = bus.wdata;
        lsq_pkg::REG_NET_ID: d.net_id = bus.wdata[7:0];
        lsq_pkg::REG_MAX_N: d.max_n = bus.wdata;
        lsq_pkg::REG_AVG_INT: d.avg_int = (bus.wdata > 16'(lsq_pkg::AVG_MAX_S)) ?
                                          lsq_pkg::AVG_MAX_S : bus.wdata[6:0];
        lsq_pkg::REG_COEF: d.coef = bus.wdata;
        default: d.coef = q.coef;
      endcase
    end
    // choosing auto text re-arms it, any other settings change stops it
    if (cfg_wr) begin
      d.dp_on = 1'b0;
      d.suspend = !(bus.addr == lsq_pkg::REG_CTRL &&
                    bus.wdata[lsq_pkg::CTRL_AUTO_LSB +: 2] == lsq_pkg::AUTO_TEXT);
    end
    // text parser: a stray byte drops the half command, a fresh 'D' re-arms
    if (rx_valid) begin
      d.got_d = (rx_data == lsq_pkg::CH_D);
      if (q.got_d && rx_data == lsq_pkg::CH_O) begin
        d.req_st = lsq_pkg::TX_TEXT;
        d.suspend = 1'b1;
        d.dp_on = 1'b0;
        d.bin_on = 1'b0;
      end
      if (q.got_d && rx_data == lsq_pkg::CH_P) begin
        d.dp_on = 1'b1;
        d.suspend = 1'b1;
        d.bin_on = 1'b0;
        d.per_cnt = 16'h0000;
      end
      // binary query: prefix, address, opcode, checksum
      d.bin_crc = crc8(rx_data, q.bin_crc);
      unique case (q.bin_idx)
        2'h0: begin
          d.bin_crc = crc8(rx_data, 8'h00);
          d.bin_idx = (rx_data == lsq_pkg::PFX_QUERY) ? 2'h1 : 2'h0;
        end
        2'h1: begin
          d.bin_addr = rx_data;
          d.bin_idx = 2'h2;
        end
        2'h2: begin
          d.bin_op = rx_data;
          d.bin_idx = 2'h3;
        end
        2'h3: begin
          d.bin_idx = 2'h0;
          if (rx_data == q.bin_crc && addr_ok &&
              (q.bin_op == lsq_pkg::OP_READ || q.bin_op == lsq_pkg::OP_CONT)) begin
            d.req_st = (q.bin_op == lsq_pkg::OP_READ) ? lsq_pkg::TX_BIN : lsq_pkg::TX_ACK;
            d.bin_on = (q.bin_op == lsq_pkg::OP_CONT);
            d.suspend = 1'b1;
            d.dp_on = 1'b0;
            d.per_cnt = 16'h0000;
          end
        end
        default: d.bin_idx = 2'h0;
      endcase
    end
    // period in seconds, only counted while some automatic output is live
    if ((text_en || bin_en) && q.period != 16'h0000) begin
      if (sec_tick) begin
        d.per_cnt = q.per_cnt + 16'h0001;
        if (q.per_cnt + 16'h0001 >= q.period) begin
          d.per_cnt = 16'h0000;
          d.per_due = 1'b1;
        end
      end
    end else begin
      d.per_cnt = 16'h0000;
      d.per_due = 1'b0;
    end
    // frequency averaging
    if (sec_tick) begin
      d.avg_f = 16'($unsigned($signed({2'b00, q.avg_f}) + avg_step));
    end
    // transmitter
    if (q.tx_st == lsq_pkg::TX_IDLE) begin
      // a due frame left over from a just-stopped mode must not leak out
      if (q.req_st != lsq_pkg::TX_IDLE || (q.per_due && (text_en || bin_en))) begin
        d.tx_st = start_st;
        d.tx_op = start_op;
        d.tx_idx = 5'h00;
        d.tx_crc = 8'h00;
        d.snap_f = meas.freq;
        d.snap_t = meas.temp;
        d.snap_n = level_out;
        d.tx_byte = frame_byte(start_st, start_op, 5'h00, meas.freq, meas.temp, level_out, q.net_id, 8'h00);
        if (q.req_st != lsq_pkg::TX_IDLE) begin
          d.req_st = lsq_pkg::TX_IDLE;
        end else begin
          d.per_due = 1'b0;
        end
      end
    end else if (tx_ready) begin
      d.tx_crc = crc_nx;
      if (q.tx_idx == frame_len(q.tx_st) - 5'h01) begin
        d.tx_st = lsq_pkg::TX_IDLE;
      end else begin
        d.tx_idx = q.tx_idx + 5'h01;
        d.tx_byte = frame_byte(q.tx_st, q.tx_op, q.tx_idx + 5'h01, q.snap_f, q.snap_t, q.snap_n,
                               q.net_id, crc_nx);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.auto_mode <= lsq_pkg::AUTO_OFF;
      q.period <= lsq_pkg::PERIOD_RST;
      q.net_id <= lsq_pkg::NET_ID_RST;
      q.max_n <= lsq_pkg::MAX_N_RST;
      q.avg_int <= lsq_pkg::AVG_INT_RST;
      q.coef <= lsq_pkg::COEF_ONE;
      q.req_st <= lsq_pkg::TX_IDLE;
      q.tx_st <= lsq_pkg::TX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rdata;
  assign tx_valid = (q.tx_st != lsq_pkg::TX_IDLE);
  assign tx_data = q.tx_byte;
  assign baud_div = lsq_pkg::BAUD_DIV;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  AST_OFF_QUIET: assert property (q.tx_st == lsq_pkg::TX_IDLE && q.req_st == lsq_pkg::TX_IDLE && !text_en &&
                                  !bin_en && !rx_valid |=> q.tx_st == lsq_pkg::TX_IDLE)
    else $error("spontaneous frame with auto output off");
  AST_READ_CMD: assert property (rx_valid && q.got_d && rx_data == lsq_pkg::CH_O |=>
                                 q.req_st == lsq_pkg::TX_TEXT || q.tx_st == lsq_pkg::TX_TEXT ##0 !q.dp_on)
    else $error("read command not answered by a text line");
  AST_DP_CMD: assert property (rx_valid && q.got_d && rx_data == lsq_pkg::CH_P |=> q.dp_on && q.suspend)
    else $error("periodic command not taken");
  AST_NET_FILTER: assert property (rx_valid && q.bin_idx == 2'h3 && q.net_mode && q.bin_addr != q.net_id &&
                                   q.bin_addr != lsq_pkg::BCAST_ID && !bus.wr |=> $stable(q.suspend) && $stable(q.bin_on))
    else $error("foreign address answered in network mode");
  AST_ZERO_PERIOD: assert property (q.period == 16'h0000 && !bus.wr |=> !q.per_due [*2])
    else $error("periodic data due with zero period");
  AST_LINE_END: assert property (q.tx_st == lsq_pkg::TX_TEXT && q.tx_idx == lsq_pkg::TXT_LEN - 5'h01 && tx_ready |->
                                 tx_data == lsq_pkg::CH_LF ##1 !tx_valid)
    else $error("text line does not end in line feed");
  AST_HEX_DIGIT: assert property (q.tx_st == lsq_pkg::TX_TEXT && q.tx_idx == 5'h09 |->
                                  (tx_data >= 8'h30 && tx_data <= 8'h39) || (tx_data >= 8'h41 && tx_data <= 8'h46))
    else $error("temperature field is not a hex digit");
  AST_CFG_STOP: assert property (bus.wr && bus.addr == lsq_pkg::REG_CTRL && !(rx_valid && q.got_d) |=>
                                 !q.dp_on && (q.suspend || q.auto_mode == lsq_pkg::AUTO_TEXT))
    else $error("settings change left periodic text running");
  AST_ID_DEFAULT: assert property ($fell(rst) |-> q.net_id == lsq_pkg::NET_ID_RST)
    else $error("network identifier not one after reset");
  AST_AVG_RANGE: assert property (q.avg_int <= lsq_pkg::AVG_MAX_S)
    else $error("averaging interval above its limit");
  AST_RESYNC: assert property (rx_valid && rx_data != lsq_pkg::CH_D |=> !q.got_d)
    else $error("half command kept after a stray byte");

  COV_READ: cover property (rx_valid && q.got_d && rx_data == lsq_pkg::CH_O ##[1:60] q.tx_st == lsq_pkg::TX_TEXT);
  COV_PERIODIC: cover property (q.dp_on && q.per_due ##1 q.tx_st == lsq_pkg::TX_TEXT);
  COV_BIN_ACK: cover property (q.tx_st == lsq_pkg::TX_ACK && q.tx_idx == 5'h04);
  COV_AUTO_BIN: cover property (q.auto_mode == lsq_pkg::AUTO_BIN && q.tx_st == lsq_pkg::TX_BIN);
endmodule

// ### verif/lsq_terminal.sv
// terminal model: sends command bytes and drains reply bytes with stalls
module lsq_terminal (
  // clock
  input wire logic sys_clk,
  // toward the responder
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready,
  // from the responder
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got_q[$];
  logic [1:0] stall_cnt;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    stall_cnt = 2'h0;
  end
  // one byte per call, a gap cycle after it; idle data shows the inverse so stale bytes never look valid
  task automatic send_byte(input logic [7:0] b);
    @(posedge sys_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
  // sink stalls one cycle in four so held bytes get exercised
  always @(posedge sys_clk) begin
    stall_cnt <= stall_cnt + 2'h1;
    tx_ready <= (stall_cnt != 2'h3);
    if (tx_valid && tx_ready) begin
      got_q.push_back(tx_data);
    end
  end
endmodule

// ### verif/level_sensor_query_responder_test.sv
// self-checking bench of the level sensor query responder
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("mismatch at %0t got %h exp %h", $time, (got), (exp)); end end
module level_sensor_query_responder_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  lsq_pkg::lsq_bus_s bus = '0;
  lsq_pkg::lsq_meas_s meas = '{freq: 16'h0af9, temp: 8'h1a, level: 16'h4000};
  logic [15:0] rd_data;
  logic [15:0] baud_div;
  logic rx_valid;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic [7:0] exp_q[$];
  logic [7:0] crc;
  int n_fail = 0;
  int checks_done = 0;
  always #12.5 sys_clk = ~sys_clk;
  // short second keeps periodic tests brief
  lsq_responder #(.CYC_PER_SEC(20)) u_dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .meas(meas), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .baud_div(baud_div));
  lsq_terminal u_term (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data));
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] b, input logic [7:0] c);
    for (int i = 0; i < 8; i++) begin
      c = ((b ^ c) & 8'h01) ? (((c ^ 8'h18) >> 1) | 8'h80) : (c >> 1);
      b = b >> 1;
    end
    return c;
  endfunction
  function automatic logic [15:0] nval(input logic [15:0] m);
    return 16'((32'(meas.level) * 32'(m)) >> 16);
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    `CHK(rd_data, e)
  endtask
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 300 && u_term.got_q.size() < n; i++) @(posedge sys_clk);
  endtask
  task automatic quiet(input int c, input int sz);
    repeat (c) @(posedge sys_clk);
    `CHK(u_term.got_q.size(), sz)
    u_term.got_q.delete();
  endtask
  task automatic text_cmd(input logic [7:0] second);
    u_term.send_byte(lsq_pkg::CH_D);
    u_term.send_byte(second);
  endtask
  task automatic chk_text(input logic [15:0] n);
    exp_q = '{8'h46, 8'h3d, hx(meas.freq[15:12]), hx(meas.freq[11:8]), hx(meas.freq[7:4]),
      hx(meas.freq[3:0]), 8'h20, 8'h74, 8'h3d, hx(meas.temp[7:4]), hx(meas.temp[3:0]), 8'h20, 8'h4e,
      8'h3d, hx(n[15:12]), hx(n[11:8]), hx(n[7:4]), hx(n[3:0]), 8'h2e, 8'h30, lsq_pkg::CH_CR, lsq_pkg::CH_LF};
    wait_bytes(22);
    for (int i = 0; i < 22; i++) `CHK(u_term.got_q[i], exp_q[i])
  endtask
  task automatic send_bin(input logic [7:0] id, input logic [7:0] op);
    crc = crc8(op, crc8(id, crc8(lsq_pkg::PFX_QUERY, 8'h00)));
    u_term.send_byte(lsq_pkg::PFX_QUERY);
    u_term.send_byte(id);
    u_term.send_byte(op);
    u_term.send_byte(crc);
  endtask
  task automatic chk_bin(input logic [7:0] op);
    wait_bytes(9);
    crc = 8'h00;
    for (int i = 0; i < 8; i++) crc = crc8(u_term.got_q[i], crc);
    `CHK(u_term.got_q[0], lsq_pkg::PFX_RESP)
    `CHK(u_term.got_q[2], op)
    `CHK(u_term.got_q[3], meas.temp)
    `CHK({u_term.got_q[7], u_term.got_q[6]}, meas.freq)
    `CHK(u_term.got_q[8], crc)
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // a hung handshake must not stall the run forever
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(lsq_pkg::REG_CTRL, 16'h0000);
    rd_chk(lsq_pkg::REG_PERIOD, 16'h0000);
    rd_chk(lsq_pkg::REG_NET_ID, 16'h0001);
    rd_chk(lsq_pkg::REG_MAX_N, 16'hffff);
    rd_chk(lsq_pkg::REG_AVG_INT, 16'h0000);
    rd_chk(lsq_pkg::REG_COEF, 16'h0100);
    rd_chk(4'hc, 16'h0000);
    `CHK(baud_div, lsq_pkg::BAUD_DIV)
    quiet(100, 0);
    text_cmd(lsq_pkg::CH_O);
    chk_text(nval(16'hffff));
    quiet(40, 22);
    text_cmd(8'h58);
    text_cmd(lsq_pkg::CH_O);
    chk_text(nval(16'hffff));
    quiet(40, 22);
    wr_reg(lsq_pkg::REG_MAX_N, 16'h8000);
    rd_chk(lsq_pkg::REG_MAX_N, 16'h8000);
    text_cmd(lsq_pkg::CH_O);
    chk_text(nval(16'h8000));
    quiet(40, 22);
    wr_reg(lsq_pkg::REG_CTRL, 16'h0008);
    text_cmd(lsq_pkg::CH_O);
    chk_text(nval(16'h8000));
    quiet(40, 22);
    // oversized interval saturates at the top of the range
    wr_reg(lsq_pkg::REG_AVG_INT, 16'h0064);
    rd_chk(lsq_pkg::REG_AVG_INT, 16'h005a);
    wr_reg(lsq_pkg::REG_CTRL, 16'h0010);
    rd_chk(lsq_pkg::REG_CTRL, 16'h0010);
    wr_reg(lsq_pkg::REG_CTRL, 16'h0000);
    wr_reg(lsq_pkg::REG_PERIOD, 16'h0002);
    rd_chk(lsq_pkg::REG_PERIOD, 16'h0002);
    text_cmd(lsq_pkg::CH_P);
    chk_text(nval(16'h8000));
    repeat (100) @(posedge sys_clk);
    `CHK(u_term.got_q.size() >= 66, 1'b1)
    text_cmd(lsq_pkg::CH_O);
    repeat (80) @(posedge sys_clk);
    u_term.got_q.delete();
    quiet(150, 0);
    wr_reg(lsq_pkg::REG_PERIOD, 16'h0000);
    text_cmd(lsq_pkg::CH_P);
    quiet(150, 0);
    rd_chk(lsq_pkg::REG_STATUS, 16'h0003);
    send_bin(8'h02, lsq_pkg::OP_READ);
    chk_bin(lsq_pkg::OP_READ);
    quiet(40, 9);
    wr_reg(lsq_pkg::REG_CTRL, 16'h0004);
    send_bin(8'h02, lsq_pkg::OP_READ);
    quiet(100, 0);
    send_bin(lsq_pkg::BCAST_ID, lsq_pkg::OP_READ);
    chk_bin(lsq_pkg::OP_READ);
    quiet(40, 9);
    wr_reg(lsq_pkg::REG_CTRL, 16'h0001);
    wr_reg(lsq_pkg::REG_PERIOD, 16'h0001);
    chk_bin(lsq_pkg::OP_CONT);
    `CHK(u_term.got_q[1], lsq_pkg::NET_ID_RST)
    repeat (60) @(posedge sys_clk);
    `CHK(u_term.got_q.size() >= 27, 1'b1)
    wr_reg(lsq_pkg::REG_CTRL, 16'h0000);
    repeat (40) @(posedge sys_clk);
    u_term.got_q.delete();
    wr_reg(lsq_pkg::REG_CTRL, 16'h0002);
    chk_text(nval(16'h8000));
    text_cmd(lsq_pkg::CH_O);
    repeat (80) @(posedge sys_clk);
    u_term.got_q.delete();
    quiet(100, 0);
    report_and_stop();
  end
endmodule
